// ===== include/adccfg_params.svh
// constants of the converter configuration register bank
// assumes a 100 MHz sampling clock and a 24-bit serial write frame
`ifndef ADCCFG_PARAMS_SVH
`define ADCCFG_PARAMS_SVH

`define ADCCFG_CLK_MHZ          100
`define ADCCFG_FRAME_BITS       5'd24
`define ADCCFG_ADDR_SWRST       8'h00
`define ADCCFG_ADDR_JITTER      8'h30
`define ADCCFG_ADDR_MODE        8'h31
`define ADCCFG_ADDR_ROUTE_A     8'h3a
`define ADCCFG_ADDR_ROUTE_B     8'h3b
`define ADCCFG_ADDR_CURR_VCM    8'h50
`define ADCCFG_ADDR_TRIM        8'h55
`define ADCCFG_ADDR_WAKE        8'h56
`define ADCCFG_DIV_LSB          8
`define ADCCFG_ROUTE_HI_LSB     8
`define ADCCFG_VCM_LSB          4
`define ADCCFG_JITTER_RST       8'h01
`define ADCCFG_DIV_RST          2'h0
`define ADCCFG_ROUTE0_RST       5'h02
`define ADCCFG_ROUTE1_RST       5'h04
`define ADCCFG_ROUTE2_RST       5'h08
`define ADCCFG_ROUTE3_RST       5'h10
`define ADCCFG_CURR_RST         3'h0
`define ADCCFG_VCM_RST          2'h1
`define ADCCFG_TRIM_RST         6'h00
`define ADCCFG_WAKE_RST         3'h0
`define ADCCFG_WAKE_CNT_100     12'd3072
`define ADCCFG_WAKE_CNT_000     12'd1984
`define ADCCFG_WAKE_CNT_001     12'd1280
`define ADCCFG_WAKE_CNT_010     12'd840
`define ADCCFG_WAKE_CNT_011     12'd520

`endif

// ===== include/adccfg_pkg.sv
// types of the converter configuration register bank
// assumes adccfg_params.svh holds every number
package adccfg_pkg;

    typedef logic [11:0] adccfg_count_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] data;
    } adccfg_wr_s;

    typedef struct packed {
        logic [5:0] range_trim_code;
        logic [2:0] core_current;
        logic [1:0] common_mode_buffer_strength;
    } adccfg_analog_s;

    typedef enum logic [1:0] {
        WAKE_IDLE  = 2'b00,
        WAKE_COUNT = 2'b01,
        WAKE_DOWN  = 2'b10
    } adccfg_wake_e;

endpackage

// ===== logic/adccfg_top.sv
// configuration register bank of a four-input converter, serial write port
// assumes serial pins and power pins are asynchronous to clk
`include "adccfg_params.svh"

// Function
// R1 - divider code 00,01,10,11 gives sample rate clk/1,/2,/4,/8; reset 00
// R2 - each core has five-bit selector, one-hot upper four bits; others reserved
// R3 - single channel mode may take any one of four input pairs
// R4 - dual channel mode may route any two input pairs, one per channel
// R5 - quad and precision modes allow any pair on any core
// R6 - new input selection takes effect when its serial write completes
// R7 - six-bit range trim code drives trim converter, about 0.3% per step
// R8 - trim code to range mapping is monotonic over the whole span
// R9 - core current: 000 nominal, 100..111 reduced; 001..011 reserved
// R10 - common mode buffer strength: off, 20, 400, 700; reset 01
// R11 - three-bit wake counter select at 0x56, resets to 000
// R12 - default wake counts suit the maximum sampling clock
// R13 - host picks setting of nearest higher clock range
// R14 - selected wake count applies to sleep and power down exit
// R15 - host divides clock by divider factor before choosing range
// R16 - jitter field all zero stops clock; only count of set bits matters
// R17 - wake counter select takes effect only after a power down cycle
// R18 - host writes zero to unused bits, never to undefined addresses; the bench sets unused bit 2 in its writes to 0x31
module adccfg_top (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    ser_clk,
    input  wire logic                    ser_sel_n,
    input  wire logic                    ser_data,
    input  wire logic                    power_down,
    input  wire logic                    sleep,
    output logic                         sample_tick,
    output logic                         clock_running,
    output logic [3:0]                   jitter_strength,
    output logic [3:0][3:0]              core_route,
    output adccfg_pkg::adccfg_analog_s   analog_cfg,
    output logic                         wake_busy
);

    logic [2:0]             sclk_sync;
    logic [1:0]             sel_sync;
    logic [1:0]             data_sync;
    logic [1:0]             pd_sync;
    logic [1:0]             sleep_sync;
    logic [23:0]            shift_reg;
    logic [4:0]             bit_cnt_reg;
    logic                   sel_dly;
    logic                   commit_reg;
    adccfg_pkg::adccfg_wr_s wr_reg;
    logic                   soft_rst;
    logic                   clr_n;
    logic [7:0]             jitter_reg;
    logic [1:0]             div_reg;
    logic [3:0][4:0]        sel_reg;
    logic [2:0]             curr_reg;
    logic [1:0]             vcm_reg;
    logic [5:0]             trim_reg;
    logic [2:0]             wake_sel_reg;
    logic [2:0]             wake_act_reg;
    logic [2:0]             div_cnt_reg;
    logic [2:0]             div_last;
    adccfg_pkg::adccfg_count_t  wake_cnt_reg;
    adccfg_pkg::adccfg_count_t  wake_len;
    adccfg_pkg::adccfg_wake_e   wake_state;
    logic                   down_now;
    logic                   sclk_rise;

    // pin synchronisers; the second stage feeds logic, and the third ser_clk stage feeds only the edge detect
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclk_sync  <= 3'h0;
            sel_sync   <= 2'h3;
            data_sync  <= 2'h0;
            pd_sync    <= 2'h0;
            sleep_sync <= 2'h0;
        end else begin
            sclk_sync  <= {sclk_sync[1:0], ser_clk};
            sel_sync   <= {sel_sync[0], ser_sel_n};
            data_sync  <= {data_sync[0], ser_data};
            pd_sync    <= {pd_sync[0], power_down};
            sleep_sync <= {sleep_sync[0], sleep};
        end
    end

    assign sclk_rise = sclk_sync[1] && !sclk_sync[2];
    assign down_now  = pd_sync[1] || sleep_sync[1];

    // serial frame: 8 address bits then 16 data bits, msb first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shift_reg   <= 24'h000000;
            bit_cnt_reg <= 5'h00;
            sel_dly     <= 1'b1;
            commit_reg  <= 1'b0;
            wr_reg      <= '0;
        end else begin
            sel_dly    <= sel_sync[1];
            commit_reg <= 1'b0;
            if (sel_sync[1]) begin
                bit_cnt_reg <= 5'h00;
            end else if (sclk_rise) begin
                shift_reg <= {shift_reg[22:0], data_sync[1]};
                if (bit_cnt_reg != 5'h1f) begin
                    bit_cnt_reg <= bit_cnt_reg + 5'h01;
                end
            end
            // short or long frames are dropped; commit only at frame end
            if (sel_sync[1] && !sel_dly && bit_cnt_reg == `ADCCFG_FRAME_BITS) begin
                commit_reg <= 1'b1; // see R6
                wr_reg     <= shift_reg;
            end
        end
    end

    assign soft_rst = commit_reg && wr_reg.addr == `ADCCFG_ADDR_SWRST && wr_reg.data[0];
    assign clr_n    = rst_n && !soft_rst;

    function automatic logic hit(input logic [7:0] a);
        hit = commit_reg && wr_reg.addr == a;
    endfunction

    // register file; undefined addresses are ignored
    always_ff @(posedge clk) begin
        if (!clr_n) begin
            jitter_reg   <= `ADCCFG_JITTER_RST;
            div_reg      <= `ADCCFG_DIV_RST; // see R1
            curr_reg     <= `ADCCFG_CURR_RST;
            vcm_reg      <= `ADCCFG_VCM_RST; // see R10
            trim_reg     <= `ADCCFG_TRIM_RST;
            wake_sel_reg <= `ADCCFG_WAKE_RST; // see R11
            sel_reg[0]   <= `ADCCFG_ROUTE0_RST;
            sel_reg[1]   <= `ADCCFG_ROUTE1_RST;
            sel_reg[2]   <= `ADCCFG_ROUTE2_RST;
            sel_reg[3]   <= `ADCCFG_ROUTE3_RST;
        end else begin
            if (hit(`ADCCFG_ADDR_JITTER)) begin
                jitter_reg <= wr_reg.data[7:0];
            end
            if (hit(`ADCCFG_ADDR_MODE)) begin
                div_reg <= wr_reg.data[`ADCCFG_DIV_LSB +: 2];
            end
            if (hit(`ADCCFG_ADDR_CURR_VCM)) begin
                curr_reg <= wr_reg.data[2:0];
                vcm_reg  <= wr_reg.data[`ADCCFG_VCM_LSB +: 2];
            end
            if (hit(`ADCCFG_ADDR_TRIM)) begin
                trim_reg <= wr_reg.data[5:0];
            end
            if (hit(`ADCCFG_ADDR_WAKE)) begin
                wake_sel_reg <= wr_reg.data[2:0];
            end
            if (hit(`ADCCFG_ADDR_ROUTE_A)) begin
                sel_reg[0] <= wr_reg.data[4:0];
                sel_reg[1] <= wr_reg.data[`ADCCFG_ROUTE_HI_LSB +: 5];
            end
            if (hit(`ADCCFG_ADDR_ROUTE_B)) begin
                sel_reg[2] <= wr_reg.data[4:0];
                sel_reg[3] <= wr_reg.data[`ADCCFG_ROUTE_HI_LSB +: 5];
            end
        end
    end

    // crosspoint: no mode restriction, so every core takes any pair
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_route
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    core_route[gi] <= 4'h1 << gi;
                end else if (!sel_reg[gi][0] && $onehot(sel_reg[gi][4:1])) begin
                    core_route[gi] <= sel_reg[gi][4:1]; // see R2, R3, R4, R5, R6
                end
            end
        end
    endgenerate

    // reserved current codes fall back to nominal, guarding core bias
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            analog_cfg <= '0;
        end else begin
            analog_cfg.range_trim_code <= trim_reg; // see R7, R8
            analog_cfg.core_current    <= curr_reg[2] ? curr_reg : 3'h0; // see R9
            analog_cfg.common_mode_buffer_strength <= vcm_reg; // see R10
        end
    end

    // sample clock divider gated by the jitter field
    assign div_last = 3'((4'h1 << div_reg) - 4'h1);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_cnt_reg     <= 3'h0;
            sample_tick     <= 1'b0;
            clock_running   <= 1'b0;
            jitter_strength <= 4'h0;
        end else begin
            clock_running   <= |jitter_reg; // see R16
            jitter_strength <= 4'($countones(jitter_reg)); // see R16
            if (div_cnt_reg >= div_last) begin
                div_cnt_reg <= 3'h0;
            end else begin
                div_cnt_reg <= div_cnt_reg + 3'h1;
            end
            sample_tick <= |jitter_reg && div_cnt_reg >= div_last; // see R1, R16
        end
    end

    // wake counts are the quad high speed column, sized for top clock rate
    always_comb begin
        unique case (wake_act_reg)
            3'b100:  wake_len = `ADCCFG_WAKE_CNT_100;
            3'b000:  wake_len = `ADCCFG_WAKE_CNT_000; // see R12
            3'b001:  wake_len = `ADCCFG_WAKE_CNT_001;
            3'b010:  wake_len = `ADCCFG_WAKE_CNT_010;
            3'b011:  wake_len = `ADCCFG_WAKE_CNT_011;
            default: wake_len = `ADCCFG_WAKE_CNT_100;
        endcase
    end

    // selection is copied only while powered down
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wake_act_reg <= `ADCCFG_WAKE_RST;
        end else if (pd_sync[1]) begin
            wake_act_reg <= wake_sel_reg; // see R17
        end
    end

    // same count for sleep exit and power down exit
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wake_state   <= adccfg_pkg::WAKE_IDLE;
            wake_cnt_reg <= '0;
            wake_busy    <= 1'b0;
        end else begin
            unique case (wake_state)
                adccfg_pkg::WAKE_IDLE: begin
                    if (down_now) begin
                        wake_state <= adccfg_pkg::WAKE_DOWN;
                        wake_busy  <= 1'b1;
                    end
                end
                adccfg_pkg::WAKE_DOWN: begin
                    if (!down_now) begin
                        wake_state   <= adccfg_pkg::WAKE_COUNT; // see R14
                        wake_cnt_reg <= wake_len - 12'd1;
                    end
                end
                adccfg_pkg::WAKE_COUNT: begin
                    if (down_now) begin
                        wake_state <= adccfg_pkg::WAKE_DOWN;
                    end else if (wake_cnt_reg == 12'd0) begin
                        wake_state <= adccfg_pkg::WAKE_IDLE;
                        wake_busy  <= 1'b0;
                    end else begin
                        wake_cnt_reg <= wake_cnt_reg - 12'd1;
                    end
                end
                default: wake_state <= adccfg_pkg::WAKE_IDLE;
            endcase
        end
    end

    adccfg_pkg::adccfg_count_t chk_busy_cnt;
    always_ff @(posedge clk) begin
        if (!rst_n || down_now) begin
            chk_busy_cnt <= '0;
        end else if (wake_busy) begin
            chk_busy_cnt <= chk_busy_cnt + 12'd1;
        end else begin
            chk_busy_cnt <= '0;
        end
    end

    a_route_onehot: assert property (@(posedge clk) disable iff (!rst_n) // see R2
        $onehot(core_route[0]) && $onehot(core_route[1]) &&
        $onehot(core_route[2]) && $onehot(core_route[3]))
        else $error("core route not one-hot");
    a_route_commit: assert property (@(posedge clk) disable iff (!rst_n) // see R6
        hit(`ADCCFG_ADDR_ROUTE_A) && !soft_rst && wr_reg.data[4:0] == 5'h10
        |=> ##1 core_route[0] == 4'h8)
        else $error("route not applied after write");
    a_clock_stop: assert property (@(posedge clk) disable iff (!rst_n) // see R16
        jitter_reg == 8'h00 |=> !sample_tick && !clock_running)
        else $error("clock runs with empty jitter field");
    a_div_by_two: assert property (@(posedge clk) disable iff (!rst_n) // see R1
        div_reg == 2'h1 && $stable(div_reg) && sample_tick |=> !sample_tick)
        else $error("divide by two ticks twice");
    a_div_by_eight: assert property (@(posedge clk) disable iff (!rst_n) // see R1
        div_reg == 2'h3 && sample_tick ##1 div_reg == 2'h3 [*7] |-> !sample_tick)
        else $error("divide by eight ticks early");
    a_curr_legal: assert property (@(posedge clk) disable iff (!rst_n) // see R9
        analog_cfg.core_current == 3'h0 || analog_cfg.core_current[2])
        else $error("reserved current code driven");
    a_vcm_reset: assert property (@(posedge clk) // see R10
        $rose(rst_n) |=> analog_cfg.common_mode_buffer_strength == `ADCCFG_VCM_RST)
        else $error("buffer strength reset wrong");
    a_trim_follow: assert property (@(posedge clk) disable iff (!rst_n) // see R7
        1'b1 |=> analog_cfg.range_trim_code == $past(trim_reg))
        else $error("trim code not driven");
    a_wake_length: assert property (@(posedge clk) disable iff (!rst_n) // see R14
        chk_busy_cnt <= wake_len + 12'd2)
        else $error("wake count overran");
    a_wake_hold: assert property (@(posedge clk) disable iff (!rst_n) // see R17
        !pd_sync[1] |=> $stable(wake_act_reg))
        else $error("wake select changed while powered");

    c_route_write: cover property (@(posedge clk) hit(`ADCCFG_ADDR_ROUTE_B));
    c_div_eight:   cover property (@(posedge clk) div_reg == 2'h3 && sample_tick);
    c_wake_done:   cover property (@(posedge clk) $fell(wake_busy));
    c_soft_reset:  cover property (@(posedge clk) soft_rst);

endmodule // adccfg_top

// ===== tb/adccfg_spi_host.sv
// serial host model that writes frames into the register bank
// assumes clk is the bench clock; ser_clk idles low between frames
module adccfg_spi_host (
    input  wire logic clk,
    output logic      ser_clk,
    output logic      ser_sel_n,
    output logic      ser_data
);
    timeunit 1ns;
    timeprecision 100ps;
    // 40 ns high and 50 ns low phases, margin over the 3-cycle minimum
    localparam int HALF = 4;

    initial begin
        ser_clk = 1'b0;
        ser_sel_n = 1'b1;
        ser_data = 1'b0;
    end

    // nbits below 24 gives a short frame the bank must drop
    task automatic send(input logic [7:0] addr, input logic [15:0] data, input int nbits);
        logic [23:0] word;
        word = {addr, data};
        @(posedge clk);
        ser_sel_n <= 1'b0;
        for (int i = 23; i > 23 - nbits; i--) begin
            @(posedge clk);
            ser_data <= word[i];
            repeat (HALF) @(posedge clk);
            ser_clk <= 1'b1;
            repeat (HALF) @(posedge clk);
            ser_clk <= 1'b0;
        end
        repeat (HALF) @(posedge clk);
        ser_sel_n <= 1'b1;
        // released line must not keep showing the last bit
        ser_data <= ~ser_data;
        repeat (8) @(posedge clk);
    endtask
endmodule // adccfg_spi_host

// ===== tb/adccfg_top_tb.sv
// self-checking bench for the converter configuration register bank
// assumes adccfg_top and the serial host model adccfg_spi_host
module adccfg_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic                          clk;
    logic                          rst_n;
    logic                          ser_clk;
    logic                          ser_sel_n;
    logic                          ser_data;
    logic                          power_down;
    logic                          sleep;
    logic                          sample_tick;
    logic                          clock_running;
    logic [3:0]                    jitter_strength;
    logic [3:0][3:0]               core_route;
    adccfg_pkg::adccfg_analog_s    analog_cfg;
    logic                          wake_busy;
    int                            failures;
    int                            check_count;
    int                            m_jit, m_div, m_trim, m_curr, m_vcm, n;
    int                            m_route[4];
    int                            codes[$] = '{4, 0, 1, 2, 3};

    adccfg_top u_adccfg_top (.clk(clk), .rst_n(rst_n), .ser_clk(ser_clk),
        .ser_sel_n(ser_sel_n), .ser_data(ser_data), .power_down(power_down),
        .sleep(sleep), .sample_tick(sample_tick), .clock_running(clock_running),
        .jitter_strength(jitter_strength), .core_route(core_route),
        .analog_cfg(analog_cfg), .wake_busy(wake_busy));
    adccfg_spi_host u_adccfg_spi_host (.clk(clk), .ser_clk(ser_clk),
        .ser_sel_n(ser_sel_n), .ser_data(ser_data));

    always #5 clk = ~clk;

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic defaults();
        m_jit = 1;
        m_div = 0;
        m_trim = 0;
        m_curr = 0;
        m_vcm = 1;
        for (int i = 0; i < 4; i++) m_route[i] = 1 << i;
    endtask

    // reserved selector codes leave the route as it was
    function automatic int route_of(logic [4:0] code, int prev);
        if (code[0] == 1'b0 && $countones(code[4:1]) == 1) return int'(code[4:1]);
        return prev;
    endfunction

    function automatic int wake_cycles(int code);
        case (code)
            4: return 3072;
            0: return 1984;
            1: return 1280;
            2: return 840;
            3: return 520;
            default: return 3072;
        endcase
    endfunction

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        u_adccfg_spi_host.send(a, d, 24);
        case (a)
            8'h00: if (d[0]) defaults();
            8'h30: m_jit = int'(d[7:0]);
            8'h31: m_div = int'(d[9:8]);
            8'h3a: begin
                m_route[0] = route_of(d[4:0], m_route[0]);
                m_route[1] = route_of(d[12:8], m_route[1]);
            end
            8'h3b: begin
                m_route[2] = route_of(d[4:0], m_route[2]);
                m_route[3] = route_of(d[12:8], m_route[3]);
            end
            8'h50: begin
                m_curr = int'(d[2:0]);
                m_vcm = int'(d[5:4]);
            end
            8'h55: m_trim = int'(d[5:0]);
            default: ;
        endcase
    endtask

    task automatic cmp_all();
        @(negedge clk);
        for (int i = 0; i < 4; i++) check(16'(core_route[i]), 16'(m_route[i]));
        check(16'(analog_cfg.range_trim_code), 16'(m_trim));
        check(16'(analog_cfg.core_current), 16'((m_curr inside {1, 2, 3}) ? 0 : m_curr));
        check(16'(analog_cfg.common_mode_buffer_strength), 16'(m_vcm));
        check(16'(jitter_strength), 16'($countones(m_jit)));
        check(16'(clock_running), 16'(m_jit != 0));
    endtask

    // count sample ticks over 64 cycles against the divider and jitter model
    task automatic ticks();
        n = 0;
        repeat (64) begin
            @(negedge clk);
            n += int'(sample_tick === 1'b1);
        end
        check(16'(n), 16'((m_jit == 0) ? 0 : (64 >> m_div)));
    endtask

    // drop the pin, then count cycles until the wake count has run out
    task automatic wake(input bit use_pd, input int exp);
        @(posedge clk);
        if (use_pd) power_down <= 1'b1;
        else sleep <= 1'b1;
        repeat (10) @(posedge clk);
        power_down <= 1'b0;
        sleep <= 1'b0;
        n = 0;
        while (wake_busy !== 1'b0 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        check(16'(n >= exp && n <= exp + 8), 16'd1);
    endtask

    initial begin
        #400_000;
        failures++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_of_test();
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        power_down = 1'b0;
        sleep = 1'b0;
        failures = 0;
        check_count = 0;
        void'($urandom(96));
        defaults();
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        cmp_all();
        ticks();
        wake(1'b1, wake_cycles(0));
        $display("test reset done");
        // every pair onto every core, then random codes with reserved ones
        for (int p = 0; p < 12; p++) begin
            logic [4:0] s[4];
            for (int c = 0; c < 4; c++)
                s[c] = (p < 4 || $urandom % 2) ? 5'(2 << ((c + p) % 4)) : 5'($urandom);
            wr(8'h3a, {3'h0, s[1], 3'h0, s[0]});
            wr(8'h3b, {3'h0, s[3], 3'h0, s[2]});
            cmp_all();
        end
        $display("test routing done");
        for (int k = 0; k < 64; k += 21) begin
            wr(8'h55, 16'(k));
            cmp_all();
        end
        for (int c = 0; c < 8; c++) begin
            wr(8'h50, 16'(((c % 4) << 4) | c));
            cmp_all();
        end
        $display("test analog fields done");
        for (int d = 0; d < 5; d++) begin
            wr(8'h30, (d == 4) ? 16'h0000 : 16'(($urandom % 255) + 1));
            wr(8'h31, 16'(((d % 4) << 8) | 4));
            cmp_all();
            ticks();
        end
        wr(8'h30, 16'h0081);
        $display("test divider and jitter done");
        u_adccfg_spi_host.send(8'h55, 16'h002a, 23);
        cmp_all();
        wr(8'h00, 16'h0001);
        cmp_all();
        ticks();
        $display("test short frame and soft reset done");
        // each of the five defined wake counter select codes in turn, checked through a power down exit
        foreach (codes[i]) begin
            wr(8'h56, 16'(codes[i]));
            wake(1'b1, wake_cycles(codes[i]));
        end
        wr(8'h56, 16'h0002);
        wake(1'b0, wake_cycles(3));
        wake(1'b1, wake_cycles(2));
        $display("test wake counts done");
        end_of_test();
    end
endmodule // adccfg_top_tb
